// *** inc/pps_pkg.sv ***
`default_nettype none
package pps_pkg;
  // word offsets on the register bus (byte addresses)
  localparam logic [3:0] PPS_ADR_B_LOWER = 4'h0;
  localparam logic [3:0] PPS_ADR_B_UPPER = 4'h4;
  localparam logic [3:0] PPS_ADR_C_LOWER = 4'h8;
  localparam logic [3:0] PPS_ADR_C_UPPER = 4'hC;
  localparam int PPS_ADR_W = 4;
  localparam int PPS_DAT_W = 32;
  localparam int PPS_REG_W = 8;
  // reset values and the implemented-bit mask of the port b lower register
  localparam logic [7:0] PPS_RST_VAL = 8'h00;
  localparam logic [7:0] PPS_B_LOWER_MASK = 8'hFC;
  // field positions (low bit of each two-bit selection field)
  localparam int PPS_B4_LSB = 0;
  localparam int PPS_B5_LSB = 2;
  localparam int PPS_C0_LSB = 0;
  localparam int PPS_C7_LSB = 6;
  // selection codes
  localparam logic [1:0] PPS_SEL_GPIO = 2'h0;
  localparam logic [1:0] PPS_SEL_LCD = 2'h1;
  localparam logic [1:0] PPS_SEL_PWM = 2'h2;
  typedef enum logic {PPS_BUS_IDLE, PPS_BUS_ACK} pps_bus_state_t;
endpackage
`default_nettype wire

// *** logic/pps_top.sv ***
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module pps_top
  import pps_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [PPS_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [PPS_DAT_W-1:0] i_wb_dat,
  output logic [PPS_DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_lcd_segment_fourteen,
  input wire logic i_lcd_segment_fifteen,
  input wire logic i_lcd_segment_sixteen,
  input wire logic i_timer_one_pwm_output,
  output logic o_timer_one_capture_input,
  input wire logic i_gpio_b4_out,
  input wire logic i_gpio_b4_oe_n,
  output logic o_gpio_b4_in,
  input wire logic i_gpio_b5_out,
  input wire logic i_gpio_b5_oe_n,
  output logic o_gpio_b5_in,
  input wire logic i_gpio_c0_out,
  input wire logic i_gpio_c0_oe_n,
  output logic o_gpio_c0_in,
  input wire logic i_gpio_c7_out,
  input wire logic i_gpio_c7_oe_n,
  output logic o_gpio_c7_in,
  input wire logic i_pin_b4_in,
  output logic o_pin_b4_out,
  output logic o_pin_b4_oe_n,
  input wire logic i_pin_b5_in,
  output logic o_pin_b5_out,
  output logic o_pin_b5_oe_n,
  input wire logic i_pin_c0_in,
  output logic o_pin_c0_out,
  output logic o_pin_c0_oe_n,
  input wire logic i_pin_c7_in,
  output logic o_pin_c7_out,
  output logic o_pin_c7_oe_n
);

  function automatic logic [1:0] field_of(input logic [PPS_REG_W-1:0] r, input int lsb);
    return r[lsb +: 2];
  endfunction

  function automatic logic [PPS_DAT_W-1:0] widen(input logic [PPS_REG_W-1:0] r);
    return {{(PPS_DAT_W-PPS_REG_W){1'b0}}, r};
  endfunction

  pps_bus_state_t bus_state_r;
  logic [PPS_REG_W-1:0] port_b_lower_pin_select_r;
  logic [PPS_REG_W-1:0] port_b_upper_pin_select_r;
  logic [PPS_REG_W-1:0] port_c_lower_pin_select_r;
  logic [PPS_REG_W-1:0] port_c_upper_pin_select_r;
  logic [PPS_DAT_W-1:0] rd_dat_nxt;
  logic bus_req;
  logic wr_commit;
  logic [1:0] pin_b4_select_field;
  logic [1:0] pin_b5_select_field;
  logic [1:0] pin_c0_select_field;
  logic [1:0] pin_c7_select_field;
  logic [PPS_REG_W-1:0] wr_byte;

  assign bus_req = i_wb_cyc && i_wb_stb;
  // writes land at the edge where ack is seen high, matching the master's view
  assign wr_commit = bus_req && i_wb_we && i_wb_sel[0] && (bus_state_r == PPS_BUS_ACK);
  assign wr_byte = i_wb_dat[PPS_REG_W-1:0];

  assign pin_b4_select_field = field_of(port_b_upper_pin_select_r, PPS_B4_LSB);
  assign pin_b5_select_field = field_of(port_b_upper_pin_select_r, PPS_B5_LSB);
  assign pin_c0_select_field = field_of(port_c_lower_pin_select_r, PPS_C0_LSB);
  assign pin_c7_select_field = field_of(port_c_upper_pin_select_r, PPS_C7_LSB);

  // one wait state, then a single-cycle ack; ack always drops for a cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_state_r <= PPS_BUS_IDLE;
    end else begin
      case (bus_state_r)
        PPS_BUS_IDLE: begin
          if (bus_req) begin
            bus_state_r <= PPS_BUS_ACK;
          end
        end
        PPS_BUS_ACK: begin
          bus_state_r <= PPS_BUS_IDLE;
        end
        default: begin
          bus_state_r <= PPS_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= bus_req && (bus_state_r == PPS_BUS_IDLE);
    end
  end

  // unmapped offsets still ack and read as zero so a stray access cannot hang
  always_comb begin
    case (i_wb_adr)
      PPS_ADR_B_LOWER: rd_dat_nxt = widen(port_b_lower_pin_select_r & PPS_B_LOWER_MASK);
      PPS_ADR_B_UPPER: rd_dat_nxt = widen(port_b_upper_pin_select_r);
      PPS_ADR_C_LOWER: rd_dat_nxt = widen(port_c_lower_pin_select_r);
      PPS_ADR_C_UPPER: rd_dat_nxt = widen(port_c_upper_pin_select_r);
      default: rd_dat_nxt = '0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_dat <= '0;
    end else if (bus_req && !i_wb_we && (bus_state_r == PPS_BUS_IDLE)) begin
      o_wb_dat <= rd_dat_nxt;
    end else if (o_wb_ack) begin
      o_wb_dat <= '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_b_lower_pin_select_r <= PPS_RST_VAL;
      port_b_upper_pin_select_r <= PPS_RST_VAL;
      port_c_lower_pin_select_r <= PPS_RST_VAL;
      port_c_upper_pin_select_r <= PPS_RST_VAL;
    end else if (wr_commit) begin
      case (i_wb_adr)
        PPS_ADR_B_LOWER: port_b_lower_pin_select_r <= wr_byte & PPS_B_LOWER_MASK;
        PPS_ADR_B_UPPER: port_b_upper_pin_select_r <= wr_byte;
        PPS_ADR_C_LOWER: port_c_lower_pin_select_r <= wr_byte;
        PPS_ADR_C_UPPER: port_c_upper_pin_select_r <= wr_byte;
        default: begin
        end
      endcase
    end
  end

  // pin paths are registered: one cycle of latency keeps every output glitch-free
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_b4_out <= 1'b0;
      o_pin_b4_oe_n <= 1'b1;
    end else if (pin_b4_select_field == PPS_SEL_LCD) begin
      o_pin_b4_out <= i_lcd_segment_fifteen;
      o_pin_b4_oe_n <= 1'b0;
    end else begin
      o_pin_b4_out <= i_gpio_b4_out;
      o_pin_b4_oe_n <= i_gpio_b4_oe_n;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_b5_out <= 1'b0;
      o_pin_b5_oe_n <= 1'b1;
    end else if (pin_b5_select_field == PPS_SEL_LCD) begin
      o_pin_b5_out <= i_lcd_segment_fourteen;
      o_pin_b5_oe_n <= 1'b0;
    end else begin
      o_pin_b5_out <= i_gpio_b5_out;
      o_pin_b5_oe_n <= i_gpio_b5_oe_n;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_c0_out <= 1'b0;
      o_pin_c0_oe_n <= 1'b1;
    end else if (pin_c0_select_field == PPS_SEL_PWM) begin
      o_pin_c0_out <= i_timer_one_pwm_output;
      o_pin_c0_oe_n <= 1'b0;
    end else begin
      o_pin_c0_out <= i_gpio_c0_out;
      o_pin_c0_oe_n <= i_gpio_c0_oe_n;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_c7_out <= 1'b0;
      o_pin_c7_oe_n <= 1'b1;
    end else if (pin_c7_select_field == PPS_SEL_LCD) begin
      o_pin_c7_out <= i_lcd_segment_sixteen;
      o_pin_c7_oe_n <= 1'b0;
    end else begin
      o_pin_c7_out <= i_gpio_c7_out;
      o_pin_c7_oe_n <= i_gpio_c7_oe_n;
    end
  end

  // pin inputs always reach the gpio reader, as a real port can read its own pin
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gpio_b4_in <= 1'b0;
      o_gpio_b5_in <= 1'b0;
      o_gpio_c0_in <= 1'b0;
      o_gpio_c7_in <= 1'b0;
    end else begin
      o_gpio_b4_in <= i_pin_b4_in;
      o_gpio_b5_in <= i_pin_b5_in;
      o_gpio_c0_in <= i_pin_c0_in;
      o_gpio_c7_in <= i_pin_c7_in;
    end
  end

  // capture is held low while the c0 field selects pwm, but the cycle after leaving pwm it can still sample the timer's own output
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_one_capture_input <= 1'b0;
    end else begin
      o_timer_one_capture_input <= (pin_c0_select_field != PPS_SEL_PWM) && i_pin_c0_in;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence req_s;
    i_wb_cyc && i_wb_stb && !o_wb_ack && (bus_state_r == PPS_BUS_IDLE);
  endsequence

  sequence ack_pulse_s;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  sequence wr_upper_b_s;
    i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && o_wb_ack && (i_wb_adr == PPS_ADR_B_UPPER);
  endsequence

  bus_ack_pulse_a: assert property (req_s |=> ack_pulse_s)
    else $error("ack did not pulse one cycle after request");

  b4_segment_a: assert property (pin_b4_select_field == PPS_SEL_LCD |=>
      (o_pin_b4_out == $past(i_lcd_segment_fifteen)) && !o_pin_b4_oe_n)
    else $error("pin b4 not driven by lcd segment fifteen");

  b4_gpio_a: assert property (pin_b4_select_field != PPS_SEL_LCD |=>
      (o_pin_b4_out == $past(i_gpio_b4_out)) && (o_pin_b4_oe_n == $past(i_gpio_b4_oe_n)))
    else $error("pin b4 not following gpio");

  b5_segment_a: assert property ((pin_b5_select_field == PPS_SEL_LCD) |=>
      (o_pin_b5_out == $past(i_lcd_segment_fourteen)) && !o_pin_b5_oe_n)
    else $error("pin b5 not driven by lcd segment fourteen");

  b5_write_path_a: assert property (wr_upper_b_s ##0 (i_wb_dat[3:2] == PPS_SEL_LCD)
      |=> ##1 (o_pin_b5_out == $past(i_lcd_segment_fourteen)))
    else $error("write of lcd code did not reach pin b5 in two cycles");

  c0_pwm_a: assert property (pin_c0_select_field == PPS_SEL_PWM |=>
      (o_pin_c0_out == $past(i_timer_one_pwm_output)) && !o_pin_c0_oe_n && !o_timer_one_capture_input)
    else $error("pin c0 not carrying timer one pwm");

  c0_capture_a: assert property (pin_c0_select_field != PPS_SEL_PWM |=>
      (o_timer_one_capture_input == $past(i_pin_c0_in)) && (o_pin_c0_out == $past(i_gpio_c0_out)))
    else $error("pin c0 gpio or capture path wrong");

  c7_segment_a: assert property (pin_c7_select_field == PPS_SEL_LCD |=>
      (o_pin_c7_out == $past(i_lcd_segment_sixteen)) && !o_pin_c7_oe_n)
    else $error("pin c7 not driven by lcd segment sixteen");

  c7_gpio_a: assert property (pin_c7_select_field != PPS_SEL_LCD |=>
      o_pin_c7_oe_n == $past(i_gpio_c7_oe_n))
    else $error("pin c7 enable not following gpio");

  b_low_zero_a: assert property ((req_s and (i_wb_adr == PPS_ADR_B_LOWER))
      |=> (o_wb_dat[1:0] == 2'h0) && (port_b_lower_pin_select_r[1:0] == 2'h0))
    else $error("unimplemented port b lower bits not zero");

  reset_clear_a: assert property ($rose(i_rst_n) |->
      (port_b_upper_pin_select_r == PPS_RST_VAL) && (port_c_lower_pin_select_r == PPS_RST_VAL)
      && (port_c_upper_pin_select_r == PPS_RST_VAL) && o_pin_b4_oe_n && o_pin_c7_oe_n)
    else $error("select fields not clear after reset");

endmodule // pps_top
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pps_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ack;
  logic pwm = 1'b0;
  logic cap;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] g_out = 4'h0;
  logic [3:0] g_oe_n = 4'hF;
  logic [3:0] ext = 4'h0;
  logic [3:0] p_out, p_oe_n, g_in, pin;
  logic [2:0] seg = 3'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, r;
  logic [7:0] m [4];
  logic [3:0] adr_tbl [4] = '{PPS_ADR_B_LOWER, PPS_ADR_B_UPPER, PPS_ADR_C_LOWER, PPS_ADR_C_UPPER};
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 32'h2FB8137E;

  always #12.5 clk = ~clk;
  // level on each pad: device drive wins while its enable is low, else the outside world
  assign pin = (~p_oe_n & p_out) | (p_oe_n & ext);

  pps_top dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_lcd_segment_fourteen(seg[0]), .i_lcd_segment_fifteen(seg[1]), .i_lcd_segment_sixteen(seg[2]),
    .i_timer_one_pwm_output(pwm), .o_timer_one_capture_input(cap),
    .i_gpio_b4_out(g_out[0]), .i_gpio_b4_oe_n(g_oe_n[0]), .o_gpio_b4_in(g_in[0]),
    .i_gpio_b5_out(g_out[1]), .i_gpio_b5_oe_n(g_oe_n[1]), .o_gpio_b5_in(g_in[1]),
    .i_gpio_c0_out(g_out[2]), .i_gpio_c0_oe_n(g_oe_n[2]), .o_gpio_c0_in(g_in[2]),
    .i_gpio_c7_out(g_out[3]), .i_gpio_c7_oe_n(g_oe_n[3]), .o_gpio_c7_in(g_in[3]),
    .i_pin_b4_in(pin[0]), .o_pin_b4_out(p_out[0]), .o_pin_b4_oe_n(p_oe_n[0]),
    .i_pin_b5_in(pin[1]), .o_pin_b5_out(p_out[1]), .o_pin_b5_oe_n(p_oe_n[1]),
    .i_pin_c0_in(pin[2]), .o_pin_c0_out(p_out[2]), .o_pin_c0_oe_n(p_oe_n[2]),
    .i_pin_c7_in(pin[3]), .o_pin_c7_out(p_out[3]), .o_pin_c7_oe_n(p_oe_n[3]));

  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; ack and read data are taken at the rising edge where ack is seen high,
  // and the request is released by that same edge, so cyc and stb stay low for the next cycle
  task automatic wb(input logic w, input logic [1:0] i, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= adr_tbl[i];
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("wb_ack", 32'h1, {31'h0, ack});
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [1:0] i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, i, d, s, q);
    if (s[0]) begin
      m[i] = d[7:0] & ((i == 2'd0) ? PPS_B_LOWER_MASK : 8'hFF);
    end
  endtask

  task automatic rd(input logic [1:0] i);
    logic [31:0] q;
    wb(1'b0, i, 32'h0, 4'hF, q);
    chk("readback", {24'h0, m[i]}, q);
  endtask

  // random pad sources held two edges so the echoed pad level has settled too
  task automatic pins();
    logic [31:0] t;
    logic [3:0] alt, src, eo, eoe;
    t = $random(seed);
    @(posedge clk);
    {g_out, g_oe_n, ext, seg, pwm} <= t[15:0];
    repeat (2) @(posedge clk);
    #1;
    alt = {m[3][7:6] == PPS_SEL_LCD, m[2][1:0] == PPS_SEL_PWM, m[1][3:2] == PPS_SEL_LCD,
           m[1][1:0] == PPS_SEL_LCD};
    src = {seg[2], pwm, seg[0], seg[1]};
    eo = (alt & src) | (~alt & g_out);
    eoe = ~alt & g_oe_n;
    chk("pin_out", {28'h0, eo}, {28'h0, p_out});
    chk("pin_oe_n", {28'h0, eoe}, {28'h0, p_oe_n});
    chk("gpio_in", {28'h0, (eoe & ext) | (~eoe & eo)}, {28'h0, g_in});
    // capture sees the pad level, which is the gpio drive itself while gpio enables the pad
    chk("capture", {31'h0, ~alt[2] & ((eoe[2] & ext[2]) | (~eoe[2] & eo[2]))}, {31'h0, cap});
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) m[i] = PPS_RST_VAL;
    for (int i = 0; i < 4; i++) rd(i);
    pins();
  endtask

  initial begin
    do_reset();
    for (int c = 0; c < 4; c++) begin
      for (int i = 1; i < 4; i++) wr(i, 32'h55 * c, 4'h1);
      pins();
    end
    wr(0, 32'hFF, 4'hF);
    rd(0);
    wr(0, 32'h03, 4'h1);
    rd(0);
    repeat (40) begin
      r = $random(seed);
      wr(r[1:0], $random(seed), r[7:4]);
      rd(r[1:0]);
      pins();
    end
    // reset again mid-run with fields set: everything must fall back to gpio
    do_reset();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule // tb
`default_nettype wire
